// >>> drhs_consts.vh
// constants for the drive halt reaction selector
// assumes inclusion by drhs_halt_sel.v and by its bench
`ifndef DRHS_CONSTS_VH
`define DRHS_CONSTS_VH
// register indices; byte address is index times four
`define DRHS_IX_FE_CODE 16'h3700
`define DRHS_IX_QS_CODE 16'h605a
`define DRHS_IX_SD_CODE 16'h605b
`define DRHS_IX_DO_CODE 16'h605c
`define DRHS_IX_HALT_CODE 16'h605d
`define DRHS_IX_FLT_CODE 16'h605e
`define DRHS_IX_CTRLWORD 16'h6040
`define DRHS_IX_MODE_REQ 16'h6060
`define DRHS_IX_MODE_SHOW 16'h6061
`define DRHS_IX_FE_WIN 16'h6065
`define DRHS_IX_QS_DECEL 16'h6085
`define DRHS_IX_FE_TMO 16'h60f8
`define DRHS_IX_ERR_HIST 16'h1003
`define DRHS_IX_HIST_SEL 16'h2003
`define DRHS_IX_IRQ_STAT 16'h2010
`define DRHS_IX_IRQ_CLR 16'h2011
`define DRHS_IX_IRQ_EN 16'h2012
`define DRHS_IX_STATUS 16'h2020
// reset values of option codes
`define DRHS_RST_FE 16'h0002
`define DRHS_RST_QS 16'h0002
`define DRHS_RST_SD 16'h0001
`define DRHS_RST_DO 16'h0001
`define DRHS_RST_HALT 16'h0001
`define DRHS_RST_FLT 16'h0002
`define DRHS_RST_DECEL 32'h00001000
// option code values
`define DRHS_OPT_NONE 16'hffff
`define DRHS_OPT_COAST 16'h0000
`define DRHS_OPT_SLOW 16'h0001
`define DRHS_OPT_QUICK 16'h0002
`define DRHS_OPT_SLOW_HOLD 16'h0005
`define DRHS_OPT_QUICK_HOLD 16'h0006
// monitoring disable values
`define DRHS_FE_WIN_OFF 32'hffffffff
`define DRHS_FE_TMO_OFF 32'h7fffffff
// operating modes that honour halt
`define DRHS_MODE_PP 8'h01
`define DRHS_MODE_VL 8'h02
`define DRHS_MODE_PV 8'h03
`define DRHS_MODE_PT 8'h04
`define DRHS_MODE_IP 8'h07
`define DRHS_CW_HALT 8
// reaction kinds
`define DRHS_ACT_NONE 2'h0
`define DRHS_ACT_COAST 2'h1
`define DRHS_ACT_SLOW 2'h2
`define DRHS_ACT_QUICK 2'h3
// target power states
`define DRHS_TGT_NONE 3'h0
`define DRHS_TGT_SOD 3'h1
`define DRHS_TGT_RTSO 3'h2
`define DRHS_TGT_SWON 3'h3
`define DRHS_TGT_QSA 3'h4
`define DRHS_TGT_FAULT 3'h5
`define DRHS_TGT_OPEN 3'h6
// interrupt bits
`define DRHS_IRQ_FAULT 0
`define DRHS_IRQ_FE 1
`define DRHS_IRQ_LIMIT 2
`define DRHS_IRQ_DONE 3
`define DRHS_IRQ_W 4
`define DRHS_RESP_OK 2'h0
`define DRHS_RESP_ERR 2'h2
`endif

// >>> drhs_halt_sel.v
// drive halt reaction selector: picks coast, slow ramp or quick ramp
// assumes a power state machine outside that pulses transition requests
// and a ramp generator that reports standstill, all on clock
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "drhs_consts.vh"
`default_nettype none
module drhs_halt_sel #(
    parameter HIST_DEPTH = 8,
    parameter HIST_AW = 3
) (
    // clock and reset
    input wire clock,
    input wire rst_b,
    input wire clk_en,
    // axi4-lite slave
    input wire [17:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [17:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // transition requests from the power state machine
    input wire req_quick_stop,
    input wire req_shutdown,
    input wire req_disable_op,
    input wire req_resume,
    // drive events
    input wire limit_switch_pin,
    input wire fault_event,
    input wire [15:0] fault_error_code,
    input wire follow_error,
    input wire at_standstill,
    input wire [31:0] mode_decel,
    // reaction outputs
    output reg driver_off_r,
    output reg ramp_active_r,
    output reg [31:0] ramp_decel_r,
    output reg reaction_done_r,
    output reg [2:0] target_state_r,
    output reg [7:0] mode_applied_r,
    output wire follow_mon_en,
    output wire irq
);

localparam ST_IDLE = 2'h0;
localparam ST_COAST = 2'h1;
localparam ST_RAMP = 2'h2;
localparam ST_HOLD = 2'h3;

// option code to reaction kind; reserved codes brake on the quick ramp
function [1:0] kind_of;
    input [15:0] code;
    if (code == `DRHS_OPT_COAST)
        kind_of = `DRHS_ACT_COAST;
    else if (code == `DRHS_OPT_SLOW || code == `DRHS_OPT_SLOW_HOLD)
        kind_of = `DRHS_ACT_SLOW;
    else
        kind_of = `DRHS_ACT_QUICK;
endfunction

// registers
reg [15:0] fe_code_r, qs_code_r, sd_code_r, do_code_r;
reg [15:0] halt_code_r, flt_code_r, ctrlword_r;
reg [7:0] mode_req_r;
reg [31:0] fe_win_r, fe_tmo_r, qs_decel_r;
reg [HIST_AW-1:0] hist_sel_r, hist_wp_r;
reg [15:0] hist_mem [0:HIST_DEPTH-1];
reg [`DRHS_IRQ_W-1:0] irq_stat_r, irq_en_r;
reg [1:0] state_r;
reg hold_exit_r;
reg lim_s1_r, lim_s2_r, lim_d_r;

// write channel
reg aw_have_r, w_have_r;
reg [15:0] aw_ix_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
assign s_axi_awready = !aw_have_r;
assign s_axi_wready = !w_have_r;
assign s_axi_arready = !s_axi_rvalid;

function known_ix;
    input [15:0] ix;
    known_ix = ix == `DRHS_IX_FE_CODE || ix == `DRHS_IX_QS_CODE ||
        ix == `DRHS_IX_SD_CODE || ix == `DRHS_IX_DO_CODE ||
        ix == `DRHS_IX_HALT_CODE || ix == `DRHS_IX_FLT_CODE ||
        ix == `DRHS_IX_CTRLWORD || ix == `DRHS_IX_MODE_REQ ||
        ix == `DRHS_IX_MODE_SHOW || ix == `DRHS_IX_FE_WIN ||
        ix == `DRHS_IX_QS_DECEL || ix == `DRHS_IX_FE_TMO ||
        ix == `DRHS_IX_ERR_HIST || ix == `DRHS_IX_HIST_SEL ||
        ix == `DRHS_IX_IRQ_STAT || ix == `DRHS_IX_IRQ_CLR ||
        ix == `DRHS_IX_IRQ_EN || ix == `DRHS_IX_STATUS;
endfunction

// unstrobed bytes land as zero
wire [31:0] wv = wdata_r & {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

// events
wire mon_off = fe_win_r == `DRHS_FE_WIN_OFF || fe_tmo_r == `DRHS_FE_TMO_OFF;
assign follow_mon_en = !mon_off;
wire fe_evt = follow_error && !mon_off && fe_code_r != `DRHS_OPT_NONE;
wire lim_evt = lim_s2_r && !lim_d_r;
wire qs_evt = req_quick_stop || lim_evt;
wire halt_mode = mode_applied_r == `DRHS_MODE_PP || mode_applied_r == `DRHS_MODE_VL ||
    mode_applied_r == `DRHS_MODE_PV || mode_applied_r == `DRHS_MODE_PT ||
    mode_applied_r == `DRHS_MODE_IP;
wire halt_req = ctrlword_r[`DRHS_CW_HALT] && halt_mode;
wire halt_ok = halt_code_r == `DRHS_OPT_SLOW || halt_code_r == `DRHS_OPT_QUICK;
wire qs_hold = qs_code_r == `DRHS_OPT_SLOW_HOLD || qs_code_r == `DRHS_OPT_QUICK_HOLD;

// pick the highest priority event: fault, following error, quick stop,
// disable operation, shutdown, halt
reg start;
reg [1:0] kind_nxt;
reg [2:0] tgt_nxt;
always @* begin
    start = 1'b1;
    kind_nxt = `DRHS_ACT_NONE;
    tgt_nxt = `DRHS_TGT_NONE;
    if (fault_event) begin
        kind_nxt = kind_of(flt_code_r);
        tgt_nxt = `DRHS_TGT_FAULT;
    end else if (fe_evt) begin
        kind_nxt = kind_of(fe_code_r);
        tgt_nxt = `DRHS_TGT_FAULT;
    end else if (qs_evt) begin
        kind_nxt = kind_of(qs_code_r);
        tgt_nxt = qs_hold ? `DRHS_TGT_QSA : `DRHS_TGT_SOD;
    end else if (req_disable_op) begin
        kind_nxt = kind_of(do_code_r);
        tgt_nxt = `DRHS_TGT_SWON;
    end else if (req_shutdown) begin
        kind_nxt = kind_of(sd_code_r);
        tgt_nxt = `DRHS_TGT_RTSO;
    end else if (halt_req && halt_ok && state_r == ST_IDLE) begin
        kind_nxt = kind_of(halt_code_r);
        tgt_nxt = `DRHS_TGT_OPEN;
    end else begin
        start = 1'b0;
    end
end

// reaction machine
always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        state_r <= ST_IDLE;
        driver_off_r <= 1'b0;
        ramp_active_r <= 1'b0;
        ramp_decel_r <= 32'h0;
        reaction_done_r <= 1'b0;
        target_state_r <= `DRHS_TGT_NONE;
        hold_exit_r <= 1'b0;
    end else if (clk_en) begin
        reaction_done_r <= 1'b0;
        if (start && !(tgt_nxt == `DRHS_TGT_OPEN && state_r != ST_IDLE)) begin
            target_state_r <= tgt_nxt;
            hold_exit_r <= 1'b0;
            if (kind_nxt == `DRHS_ACT_COAST) begin
                state_r <= ST_COAST;
                driver_off_r <= 1'b1;
                ramp_active_r <= 1'b0;
            end else begin
                state_r <= ST_RAMP;
                driver_off_r <= 1'b0;
                ramp_active_r <= 1'b1;
                ramp_decel_r <= kind_nxt == `DRHS_ACT_QUICK ?
                    qs_decel_r : mode_decel;
            end
        end else begin
            case (state_r)
                ST_COAST: begin
                    // driver stays off until the next request re-enables
                    reaction_done_r <= 1'b1;
                    state_r <= ST_IDLE;
                end
                ST_RAMP: begin
                    if (at_standstill) begin
                        ramp_active_r <= 1'b0;
                        reaction_done_r <= 1'b1;
                        if (target_state_r == `DRHS_TGT_QSA ||
                            target_state_r == `DRHS_TGT_OPEN)
                            state_r <= ST_HOLD;
                        else
                            state_r <= ST_IDLE;
                    end
                end
                ST_HOLD: begin
                    // energized standstill; halt leaves when bit 8 drops
                    if ((target_state_r == `DRHS_TGT_QSA && req_resume) ||
                        (target_state_r == `DRHS_TGT_OPEN && !halt_req)) begin
                        state_r <= ST_IDLE;
                        hold_exit_r <= 1'b1;
                        target_state_r <= `DRHS_TGT_NONE;
                    end
                end
                default: begin
                    if (req_resume)
                        driver_off_r <= 1'b0;
                end
            endcase
        end
    end
end

// applied mode follows the request, but not in the middle of a ramp
always @(posedge clock or negedge rst_b) begin
    if (!rst_b)
        mode_applied_r <= 8'h0;
    else if (clk_en && state_r != ST_RAMP)
        mode_applied_r <= mode_req_r;
end

// limit switch pin synchroniser
always @(posedge clock or negedge rst_b) begin
    if (!rst_b)
        {lim_d_r, lim_s2_r, lim_s1_r} <= 3'h0;
    else if (clk_en)
        {lim_d_r, lim_s2_r, lim_s1_r} <= {lim_s2_r, lim_s1_r, limit_switch_pin};
end

// error history ring, newest at the write pointer minus one
always @(posedge clock) begin
    if (clk_en && fault_event)
        hist_mem[hist_wp_r] <= fault_error_code;
end

// interrupt status, set wins over clear
wire [`DRHS_IRQ_W-1:0] irq_set = {reaction_done_r, lim_evt, fe_evt, fault_event};
wire wr_clr = wr_go && aw_ix_r == `DRHS_IX_IRQ_CLR;
always @(posedge clock or negedge rst_b) begin
    if (!rst_b)
        irq_stat_r <= {`DRHS_IRQ_W{1'b0}};
    else if (clk_en)
        irq_stat_r <= (irq_stat_r & ~(wr_clr ? wv[`DRHS_IRQ_W-1:0] :
            {`DRHS_IRQ_W{1'b0}})) | irq_set;
end
assign irq = |(irq_stat_r & irq_en_r);

// register writes
always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        aw_ix_r <= 16'h0;
        wdata_r <= 32'h0;
        wstrb_r <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `DRHS_RESP_OK;
        fe_code_r <= `DRHS_RST_FE;
        qs_code_r <= `DRHS_RST_QS;
        sd_code_r <= `DRHS_RST_SD;
        do_code_r <= `DRHS_RST_DO;
        halt_code_r <= `DRHS_RST_HALT;
        flt_code_r <= `DRHS_RST_FLT;
        ctrlword_r <= 16'h0;
        mode_req_r <= 8'h0;
        fe_win_r <= 32'h0;
        fe_tmo_r <= 32'h0;
        qs_decel_r <= `DRHS_RST_DECEL;
        hist_sel_r <= {HIST_AW{1'b0}};
        hist_wp_r <= {HIST_AW{1'b0}};
        irq_en_r <= {`DRHS_IRQ_W{1'b0}};
    end else if (clk_en) begin
        if (fault_event)
            hist_wp_r <= hist_wp_r + 1'b1;
        if (s_axi_awvalid && !aw_have_r) begin
            aw_have_r <= 1'b1;
            aw_ix_r <= s_axi_awaddr[17:2];
        end
        if (s_axi_wvalid && !w_have_r) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known_ix(aw_ix_r) ? `DRHS_RESP_OK : `DRHS_RESP_ERR;
            if (aw_ix_r == `DRHS_IX_FE_CODE)
                fe_code_r <= wv[15:0];
            else if (aw_ix_r == `DRHS_IX_QS_CODE)
                qs_code_r <= wv[15:0];
            else if (aw_ix_r == `DRHS_IX_SD_CODE)
                sd_code_r <= wv[15:0];
            else if (aw_ix_r == `DRHS_IX_DO_CODE)
                do_code_r <= wv[15:0];
            else if (aw_ix_r == `DRHS_IX_HALT_CODE)
                halt_code_r <= wv[15:0];
            else if (aw_ix_r == `DRHS_IX_FLT_CODE)
                flt_code_r <= wv[15:0];
            else if (aw_ix_r == `DRHS_IX_CTRLWORD)
                ctrlword_r <= wv[15:0];
            else if (aw_ix_r == `DRHS_IX_MODE_REQ)
                mode_req_r <= wv[7:0];
            else if (aw_ix_r == `DRHS_IX_FE_WIN)
                fe_win_r <= wv;
            else if (aw_ix_r == `DRHS_IX_QS_DECEL)
                qs_decel_r <= wv;
            else if (aw_ix_r == `DRHS_IX_FE_TMO)
                fe_tmo_r <= wv;
            else if (aw_ix_r == `DRHS_IX_HIST_SEL)
                hist_sel_r <= wv[HIST_AW-1:0];
            else if (aw_ix_r == `DRHS_IX_IRQ_EN)
                irq_en_r <= wv[`DRHS_IRQ_W-1:0];
        end
    end
end

// register reads
wire [15:0] ar_ix = s_axi_araddr[17:2];
wire [HIST_AW-1:0] hist_ix = hist_wp_r - 1'b1 - hist_sel_r;
reg [31:0] rd_val;
always @* begin
    rd_val = 32'h0;
    if (ar_ix == `DRHS_IX_FE_CODE)
        rd_val = {16'h0, fe_code_r};
    else if (ar_ix == `DRHS_IX_QS_CODE)
        rd_val = {16'h0, qs_code_r};
    else if (ar_ix == `DRHS_IX_SD_CODE)
        rd_val = {16'h0, sd_code_r};
    else if (ar_ix == `DRHS_IX_DO_CODE)
        rd_val = {16'h0, do_code_r};
    else if (ar_ix == `DRHS_IX_HALT_CODE)
        rd_val = {16'h0, halt_code_r};
    else if (ar_ix == `DRHS_IX_FLT_CODE)
        rd_val = {16'h0, flt_code_r};
    else if (ar_ix == `DRHS_IX_CTRLWORD)
        rd_val = {16'h0, ctrlword_r};
    else if (ar_ix == `DRHS_IX_MODE_REQ)
        rd_val = {24'h0, mode_req_r};
    else if (ar_ix == `DRHS_IX_MODE_SHOW)
        rd_val = {24'h0, mode_applied_r};
    else if (ar_ix == `DRHS_IX_FE_WIN)
        rd_val = fe_win_r;
    else if (ar_ix == `DRHS_IX_QS_DECEL)
        rd_val = qs_decel_r;
    else if (ar_ix == `DRHS_IX_FE_TMO)
        rd_val = fe_tmo_r;
    else if (ar_ix == `DRHS_IX_ERR_HIST)
        rd_val = {16'h0, hist_mem[hist_ix]};
    else if (ar_ix == `DRHS_IX_HIST_SEL)
        rd_val = {{(32-HIST_AW){1'b0}}, hist_sel_r};
    else if (ar_ix == `DRHS_IX_IRQ_STAT)
        rd_val = {{(32-`DRHS_IRQ_W){1'b0}}, irq_stat_r};
    else if (ar_ix == `DRHS_IX_IRQ_EN)
        rd_val = {{(32-`DRHS_IRQ_W){1'b0}}, irq_en_r};
    else if (ar_ix == `DRHS_IX_STATUS)
        rd_val = {24'h0, follow_mon_en, hold_exit_r, target_state_r, state_r};
end

always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `DRHS_RESP_OK;
    end else if (clk_en) begin
        if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            // the clear register is write-only and reads as error
            s_axi_rresp <= known_ix(ar_ix) && ar_ix != `DRHS_IX_IRQ_CLR ?
                `DRHS_RESP_OK : `DRHS_RESP_ERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// >>> drhs_halt_sel_props.sv
// port assertions for the drive halt reaction selector
// assumes one clock domain and the bind below
`default_nettype none
module drhs_halt_sel_props (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // events
    input wire logic req_quick_stop,
    input wire logic req_shutdown,
    input wire logic req_disable_op,
    input wire logic fault_event,
    input wire logic follow_error,
    input wire logic limit_switch_pin,
    input wire logic at_standstill,
    // reactions
    input wire logic driver_off_r,
    input wire logic ramp_active_r,
    input wire logic [31:0] ramp_decel_r,
    input wire logic reaction_done_r,
    input wire logic [2:0] target_state_r,
    input wire logic follow_mon_en
);
    timeunit 1ns;
    timeprecision 1ps;
    // a new event may restart a running reaction, so ramp checks need quiet
    wire logic quiet = !(fault_event || follow_error || req_quick_stop || req_shutdown
        || req_disable_op);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    property p_done_pulse;
        reaction_done_r |=> !reaction_done_r;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
    property p_ramp_end;
        clk_en && ramp_active_r && at_standstill && quiet |=> !ramp_active_r && reaction_done_r;
    endproperty
    a_ramp_end: assert property (p_ramp_end) else $error("ramp not ended at standstill");
    property p_coast;
        $rose(driver_off_r) |=> reaction_done_r;
    endproperty
    a_coast: assert property (p_coast) else $error("coast without done");
    property p_decel;
        clk_en && ramp_active_r && quiet |=> ramp_active_r -> $stable(ramp_decel_r);
    endproperty
    a_decel: assert property (p_decel) else $error("decel moved in ramp");
    property p_fe_off;
        follow_error && !follow_mon_en && !fault_event && !ramp_active_r && !driver_off_r
            |=> !ramp_active_r && !driver_off_r;
    endproperty
    a_fe_off: assert property (p_fe_off) else $error("reaction with monitor off");
    property p_limit;
        $rose(limit_switch_pin) && !ramp_active_r && !driver_off_r
            |-> ##[1:5] (ramp_active_r || driver_off_r);
    endproperty
    a_limit: assert property (p_limit) else $error("limit switch ignored");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_wans;
        clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_wans: assert property (p_wans) else $error("write response late");
    property p_rans;
        clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    c_hold: cover property (reaction_done_r && target_state_r == 3'h4);
    c_ramp: cover property (ramp_active_r && at_standstill);
    c_coast: cover property ($rose(driver_off_r));
endmodule
bind drhs_halt_sel drhs_halt_sel_props chk_u (.*);
`default_nettype wire

// >>> drhs_halt_sel_tb_top.sv
// self-checking bench for the reaction selector
// assumes the selector, its checker and the ramp model
`include "drhs_consts.vh"
`default_nettype none
module drhs_halt_sel_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] QD = 32'h2222;
    localparam logic [1:0] NO = `DRHS_ACT_NONE, CO = `DRHS_ACT_COAST, SL = `DRHS_ACT_SLOW;
    localparam logic [1:0] QK = `DRHS_ACT_QUICK;
    localparam logic [15:0] OC = `DRHS_OPT_COAST, OS = `DRHS_OPT_SLOW, OQ = `DRHS_OPT_QUICK;
    logic [15:0] ixs [0:5] = '{`DRHS_IX_QS_CODE, `DRHS_IX_SD_CODE, `DRHS_IX_DO_CODE,
        `DRHS_IX_FLT_CODE, `DRHS_IX_FE_CODE, `DRHS_IX_QS_CODE};
    logic clock = 0, rst_b = 0, clk_en = 1, slow = 0, at_standstill;
    logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, mode_decel = 32'h3333, rd, s_axi_rdata, ramp_decel_r;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, req_quick_stop = 0, req_shutdown = 0, req_disable_op = 0;
    logic req_resume = 0, limit_switch_pin = 0, fault_event = 0, follow_error = 0;
    logic [15:0] fault_error_code = 16'hbeef;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic driver_off_r, ramp_active_r, reaction_done_r, follow_mon_en, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [2:0] target_state_r;
    logic [7:0] mode_applied_r;
    int mismatches = 0, n_tests = 0;
    always #4 clock = ~clock;
    drhs_halt_sel dut_u (.*);
    drhs_ramp_model ramp_u (.*);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task axw(input logic [15:0] ix, input logic [31:0] d);
        logic a, w, b;
        @(posedge clock);
        s_axi_awaddr <= {ix, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        forever begin
            @(negedge clock);
            a = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clock);
            if (a) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
            if (b) break;
        end
        s_axi_bready <= 0;
        // outputs launched at the answer edge settle before the caller looks
        @(negedge clock);
        chk(rsp, `DRHS_RESP_OK);
    endtask
    task axr(input logic [15:0] ix);
        logic a, v;
        @(posedge clock);
        s_axi_araddr <= {ix, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        forever begin
            @(negedge clock);
            a = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clock);
            if (a) s_axi_arvalid <= 0;
            if (v) break;
        end
        s_axi_rready <= 0;
    endtask
    task rchk(input logic [15:0] ix, input logic [31:0] exp);
        axr(ix);
        chk(rd, exp);
    endtask
    task react(input int ev, input logic [15:0] code, input logic [1:0] act);
        int n;
        logic [2:0] tgt;
        tgt = ev == 1 ? `DRHS_TGT_RTSO : ev == 2 ? `DRHS_TGT_SWON : ev inside {3, 4} ?
            `DRHS_TGT_FAULT : code inside {`DRHS_OPT_SLOW_HOLD, `DRHS_OPT_QUICK_HOLD} ?
            `DRHS_TGT_QSA : `DRHS_TGT_SOD;
        axw(ixs[ev], {16'h0, code});
        @(posedge clock);
        case (ev)
            0: req_quick_stop <= 1;
            1: req_shutdown <= 1;
            2: req_disable_op <= 1;
            3: fault_event <= 1;
            4: follow_error <= 1;
            default: limit_switch_pin <= 1;
        endcase
        @(posedge clock);
        {req_quick_stop, req_shutdown, req_disable_op, fault_event, follow_error} <= 5'h00;
        @(negedge clock);
        for (n = 0; n < 6 && !(driver_off_r || ramp_active_r); n++) @(negedge clock);
        chk(driver_off_r, act == CO);
        chk(ramp_active_r, act > CO);
        if (act > CO)
            chk(ramp_decel_r, act == QK ? QD : mode_decel);
        if (act != NO) begin
            for (n = 0; n < 60 && reaction_done_r !== 1'b1; n++) @(negedge clock);
            chk(reaction_done_r, 1);
            chk(target_state_r, tgt);
        end
        @(posedge clock);
        limit_switch_pin <= 0;
        req_resume <= 1;
        @(posedge clock);
        req_resume <= 0;
        @(negedge clock);
        chk(driver_off_r, 0);
        slow = !slow;
    endtask
    task t_reset;
        rchk(`DRHS_IX_FE_CODE, `DRHS_RST_FE);
        rchk(`DRHS_IX_QS_CODE, `DRHS_RST_QS);
        rchk(`DRHS_IX_SD_CODE, `DRHS_RST_SD);
        rchk(`DRHS_IX_DO_CODE, `DRHS_RST_DO);
        rchk(`DRHS_IX_HALT_CODE, `DRHS_RST_HALT);
        rchk(`DRHS_IX_FLT_CODE, `DRHS_RST_FLT);
        rchk(`DRHS_IX_QS_DECEL, `DRHS_RST_DECEL);
        axr(16'h0004);
        chk(rsp, `DRHS_RESP_ERR);
        $display("test reset done");
    endtask
    task t_qs;
        react(0, OC, CO);
        react(0, OS, SL);
        react(0, OQ, QK);
        react(0, `DRHS_OPT_SLOW_HOLD, SL);
        react(0, `DRHS_OPT_QUICK_HOLD, QK);
        react(5, `DRHS_OPT_QUICK_HOLD, QK);
        $display("test quick stop done");
    endtask
    task t_sd_do;
        react(1, OC, CO);
        react(1, OS, SL);
        react(1, 16'h8000, QK);
        react(2, OC, CO);
        react(2, OS, SL);
        react(2, 16'h0002, QK);
        $display("test shutdown and disable done");
    endtask
    task t_halt;
        logic [55:0] modes;
        logic [7:0] m;
        logic [15:0] c;
        int n;
        // last two cases: mode without halt, then the coast code, which halt does not accept
        modes = 56'h01020304070601;
        for (int i = 0; i < 7; i++) begin
            m = modes[55 - 8 * i -: 8];
            c = (i == 6) ? 16'h0000 : 16'((i % 2) + 1);
            axw(`DRHS_IX_MODE_REQ, {24'h0, m});
            chk(mode_applied_r, m);
            rchk(`DRHS_IX_MODE_SHOW, {24'h0, m});
            axw(`DRHS_IX_HALT_CODE, {16'h0, c});
            axw(`DRHS_IX_CTRLWORD, 32'h1 << `DRHS_CW_HALT);
            for (n = 0; n < 6 && !ramp_active_r; n++) @(negedge clock);
            chk(ramp_active_r, i < 5);
            if (i < 5) begin
                chk(ramp_decel_r, c == OQ ? QD : mode_decel);
                for (n = 0; n < 60 && reaction_done_r !== 1'b1; n++) @(negedge clock);
                chk(target_state_r, `DRHS_TGT_OPEN);
            end
            axw(`DRHS_IX_CTRLWORD, 32'h0);
            chk(target_state_r, `DRHS_TGT_NONE);
        end
        $display("test halt done");
    endtask
    task t_fault;
        react(3, OS, SL);
        chk(irq, 0);
        axw(`DRHS_IX_IRQ_EN, 32'h1 << `DRHS_IRQ_FAULT);
        chk(irq, 1);
        axw(`DRHS_IX_IRQ_CLR, 32'h1 << `DRHS_IRQ_FAULT);
        chk(irq, 0);
        react(3, OC, CO);
        react(3, OQ, QK);
        rchk(`DRHS_IX_ERR_HIST, {16'h0, fault_error_code});
        chk(irq, 1);
        axw(`DRHS_IX_IRQ_EN, 32'h0);
        $display("test fault done");
    endtask
    task t_fe;
        axw(`DRHS_IX_FE_WIN, `DRHS_FE_WIN_OFF);
        chk(follow_mon_en, 0);
        react(4, OQ, NO);
        axw(`DRHS_IX_FE_WIN, 32'h0);
        axw(`DRHS_IX_FE_TMO, `DRHS_FE_TMO_OFF);
        chk(follow_mon_en, 0);
        axw(`DRHS_IX_FE_TMO, 32'h7ffffffe);
        chk(follow_mon_en, 1);
        react(4, `DRHS_OPT_NONE, NO);
        react(4, OC, CO);
        react(4, OS, SL);
        $display("test following error done");
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        finish_test;
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1;
        t_reset;
        axw(`DRHS_IX_QS_DECEL, QD);
        t_qs;
        t_sd_do;
        t_halt;
        t_fault;
        t_fe;
        finish_test;
    end
endmodule
`default_nettype wire

// >>> drhs_ramp_model.sv
// ramp generator stand-in: reports standstill after a braking ramp
// assumes the selector's clock; slow picks a long ramp
`default_nettype none
module drhs_ramp_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // control
    input wire logic slow,
    input wire logic ramp_active_r,
    // status
    output var logic at_standstill
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt_r;
    // standstill is reported only while a ramp runs and for one cycle after it ends
    always_ff @(posedge clock) begin
        cnt_r <= rst_b && ramp_active_r ? cnt_r + 5'h01 : 5'h00;
        at_standstill <= rst_b && ramp_active_r && cnt_r >= (slow ? 5'h12 : 5'h01);
    end
endmodule
`default_nettype wire
